// ### rtl/slcf_pkg.sv
// Purpose: Constants for strap latch and clock fanout block
// Assumes: 10 MHz reference clock
// Notes: Dual pin order, counts, one-hot states
// Contract
// - Thirteen memory clock copies follow the memory clock input.
// - Power-down low forces all memory clock copies inactive.
// - First 2 ms: five dual pins three-stated, read as inputs.
// - At period end each pin level is latched, low 0, high 1.
// - Output buffers enable only after straps are latched.
// - Interval timer starts when power-on detector reports supply good.
// - Latches hold until power cycle; nothing else resamples them.
// - One truncated processor clock cycle may occur at output enable.
// - Function strap picks pin 2: 0 clock stop input, 1 reference out.
// - Four frequency select bits index the frequency table.
package slcf_pkg;
	localparam int unsigned REF_CLK_HZ = 10_000_000;
	localparam int unsigned SAMPLE_TIME_US = 2000;
	localparam int unsigned SAMPLE_CYCLES =
		SAMPLE_TIME_US * (REF_CLK_HZ / 1_000_000);
	localparam int unsigned CNT_W = 15;
	localparam int unsigned N_MEM_CLK = 13;
	localparam int unsigned N_DUAL = 5;
	localparam int unsigned FS_W = 4;
	// Dual pin order in the strap vector
	localparam int unsigned PIN_FREQ0 = 0;
	localparam int unsigned PIN_FREQ1 = 1;
	localparam int unsigned PIN_FREQ2 = 2;
	localparam int unsigned PIN_FREQ3 = 3;
	localparam int unsigned PIN_MODE = 4;
	localparam logic [N_DUAL-1:0] STRAP_DEFAULT = 5'h00;
	localparam logic [N_DUAL-1:0] OE_N_OFF = 5'h1F;
	localparam logic [N_DUAL-1:0] OE_N_ON = 5'h00;
	typedef enum logic [2:0] {
		SLCF_WAIT_POR = 3'h1,
		SLCF_SAMPLE = 3'h2,
		SLCF_RUN = 3'h4
	} slcf_state_t;
endpackage

// ### rtl/slcf_sync.sv
// Purpose: Two flip-flop synchroniser, parameterised width
// Assumes: Asynchronous input, destination clock i_ref_clk
// Notes: First stage read only by second stage
`timescale 1ns/1ps
module slcf_sync #(
	parameter int unsigned W = 1
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end
	assign o_sync = sync_q;
endmodule

// ### rtl/slcf_top.sv
// Purpose: Strap sampling, output enable sequencing, memory clock fanout
// Assumes: i_rstn is the power-on reset; i_supply_good from detector
// Notes: Memory clock path is combinational, not resynchronised
`timescale 1ns/1ps
module slcf_top #(
	parameter int unsigned SAMPLE_CYCLES = slcf_pkg::SAMPLE_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_supply_good,
	input wire logic i_memory_clock_in,
	input wire logic i_power_down_n,
	input wire logic [slcf_pkg::N_DUAL-1:0] i_dual_pin,
	input wire logic [slcf_pkg::N_DUAL-1:0] i_dual_clk,
	input wire logic i_ref_clk_src,
	output logic [slcf_pkg::N_MEM_CLK-1:0] o_memory_clock_copies,
	output logic [slcf_pkg::N_DUAL-1:0] o_dual_pin,
	output logic [slcf_pkg::N_DUAL-1:0] o_dual_pin_oe_n,
	output logic [slcf_pkg::FS_W-1:0] o_freq_select_straps,
	output logic o_pin2_is_ref_out,
	output logic o_pin2_oe_n,
	output logic o_pin2_out,
	output logic o_straps_valid,
	output logic o_latch_strobe,
	output logic o_outputs_enabled
);
	logic supply_good_s;
	logic [slcf_pkg::N_DUAL-1:0] pin_s;
	slcf_pkg::slcf_state_t state_q;
	slcf_pkg::slcf_state_t state_d;
	logic [slcf_pkg::CNT_W-1:0] cnt_q;
	logic [slcf_pkg::CNT_W-1:0] cnt_d;
	logic [slcf_pkg::N_DUAL-1:0] strap_q;
	logic [slcf_pkg::N_DUAL-1:0] strap_d;
	logic valid_q;
	logic valid_d;
	logic strobe_q;
	logic strobe_d;
	logic oe_q;
	logic oe_d;
	logic [slcf_pkg::CNT_W-1:0] last_cnt;
	logic cnt_done;
	logic [slcf_pkg::N_DUAL-1:0] dual_oe_n_q;
	logic [slcf_pkg::N_DUAL-1:0] dual_oe_n_d;
	logic pin2_oe_n_q;
	logic pin2_oe_n_d;

	assign last_cnt = slcf_pkg::CNT_W'(SAMPLE_CYCLES - 1);

	slcf_sync #(
		.W(1)
	) u_sync_por (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_async(i_supply_good),
		.o_sync(supply_good_s)
	);

	// One synchroniser per strap pin
	slcf_sync #(
		.W(1)
	) u_sync_freq0 (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_async(i_dual_pin[slcf_pkg::PIN_FREQ0]),
		.o_sync(pin_s[slcf_pkg::PIN_FREQ0])
	);

	slcf_sync #(
		.W(1)
	) u_sync_freq1 (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_async(i_dual_pin[slcf_pkg::PIN_FREQ1]),
		.o_sync(pin_s[slcf_pkg::PIN_FREQ1])
	);

	slcf_sync #(
		.W(1)
	) u_sync_freq2 (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_async(i_dual_pin[slcf_pkg::PIN_FREQ2]),
		.o_sync(pin_s[slcf_pkg::PIN_FREQ2])
	);

	slcf_sync #(
		.W(1)
	) u_sync_freq3 (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_async(i_dual_pin[slcf_pkg::PIN_FREQ3]),
		.o_sync(pin_s[slcf_pkg::PIN_FREQ3])
	);

	slcf_sync #(
		.W(1)
	) u_sync_mode (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_async(i_dual_pin[slcf_pkg::PIN_MODE]),
		.o_sync(pin_s[slcf_pkg::PIN_MODE])
	);

	// Sample window ends on the last count
	assign cnt_done = (state_q == slcf_pkg::SLCF_SAMPLE)
		&& (cnt_q == last_cnt);

	// Sequencer: wait for supply, sample window, run
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			slcf_pkg::SLCF_WAIT_POR:
			begin
				cnt_d = '0;
				if (supply_good_s)
				begin
					state_d = slcf_pkg::SLCF_SAMPLE;
				end
			end
			slcf_pkg::SLCF_SAMPLE:
			begin
				if (cnt_done)
				begin
					state_d = slcf_pkg::SLCF_RUN;
				end
				else
				begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			slcf_pkg::SLCF_RUN:
			begin
				state_d = slcf_pkg::SLCF_RUN;
			end
			default:
			begin
				state_d = slcf_pkg::SLCF_WAIT_POR;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_q <= slcf_pkg::SLCF_WAIT_POR;
			cnt_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Strap latch: single capture, one-cycle strobe
	always_comb
	begin
		strap_d = strap_q;
		valid_d = valid_q;
		strobe_d = 1'b0;
		if (cnt_done && !valid_q)
		begin
			strap_d = pin_s;
			valid_d = 1'b1;
			strobe_d = 1'b1;
		end
	end

	// Only power-on reset clears the straps
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			strap_q <= slcf_pkg::STRAP_DEFAULT;
			valid_q <= 1'b0;
			strobe_q <= 1'b0;
		end
		else
		begin
			strap_q <= strap_d;
			valid_q <= valid_d;
			strobe_q <= strobe_d;
		end
	end

	// Output enable: one cycle after the latch
	always_comb
	begin
		oe_d = oe_q;
		dual_oe_n_d = dual_oe_n_q;
		pin2_oe_n_d = pin2_oe_n_q;
		if ((state_q == slcf_pkg::SLCF_RUN) && valid_q)
		begin
			oe_d = 1'b1;
			dual_oe_n_d = slcf_pkg::OE_N_ON;
			pin2_oe_n_d = !strap_q[slcf_pkg::PIN_MODE];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			oe_q <= 1'b0;
			dual_oe_n_q <= slcf_pkg::OE_N_OFF;
			pin2_oe_n_q <= 1'b1;
		end
		else
		begin
			oe_q <= oe_d;
			dual_oe_n_q <= dual_oe_n_d;
			pin2_oe_n_q <= pin2_oe_n_d;
		end
	end

	// Memory clock fanout, gated by power-down
	assign o_memory_clock_copies = i_power_down_n
		? {slcf_pkg::N_MEM_CLK{i_memory_clock_in}}
		: '0;

	// Dual pins three-stated until enable; clocks may start mid-cycle
	assign o_dual_pin_oe_n = dual_oe_n_q;
	assign o_dual_pin = oe_q ? i_dual_clk : '0;

	// Latched configuration for the synthesiser
	assign o_freq_select_straps =
		strap_q[slcf_pkg::PIN_FREQ3:slcf_pkg::PIN_FREQ0];
	assign o_pin2_is_ref_out = strap_q[slcf_pkg::PIN_MODE];
	assign o_pin2_oe_n = pin2_oe_n_q;
	assign o_pin2_out = pin2_oe_n_q ? 1'b0 : i_ref_clk_src;
	assign o_straps_valid = valid_q;
	assign o_latch_strobe = strobe_q;
	assign o_outputs_enabled = oe_q;
endmodule

// ### verif/slcf_props.sv
// Purpose: Port checker for slcf_top
// Assumes: One clock, async low reset
// Notes: Bound below
`timescale 1ns/1ps
module slcf_props (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_memory_clock_in,
	input wire logic i_power_down_n,
	input wire logic [12:0] o_memory_clock_copies,
	input wire logic [4:0] o_dual_pin_oe_n,
	input wire logic [3:0] o_freq_select_straps,
	input wire logic o_pin2_is_ref_out,
	input wire logic o_pin2_oe_n,
	input wire logic o_straps_valid,
	input wire logic o_latch_strobe,
	input wire logic o_outputs_enabled
);
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);
	a_copy_on: assert property (i_power_down_n |->
		o_memory_clock_copies == {13{i_memory_clock_in}}) else $error("copy");
	a_copy_off: assert property (!i_power_down_n |->
		o_memory_clock_copies == 13'h0000) else $error("pd");
	a_hiz_early: assert property (!o_straps_valid |->
		o_dual_pin_oe_n == 5'h1F) else $error("hiz");
	a_oe_late: assert property (o_outputs_enabled |->
		o_straps_valid && o_dual_pin_oe_n == 5'h00) else $error("oe");
	a_one_shot: assert property (o_latch_strobe |=>
		!o_latch_strobe) else $error("shot");
	a_strobe_rise: assert property ($rose(o_straps_valid) |->
		o_latch_strobe ##1 o_outputs_enabled) else $error("stb");
	a_hold_fs: assert property (o_straps_valid |=>
		$stable(o_freq_select_straps)) else $error("hold");
	a_fs_default: assert property (!o_straps_valid |->
		o_freq_select_straps == 4'h0) else $error("dflt");
	a_pin2_role: assert property (o_outputs_enabled |->
		o_pin2_oe_n == !o_pin2_is_ref_out) else $error("pin2");
	a_pin2_idle: assert property (!o_outputs_enabled |->
		o_pin2_oe_n) else $error("pin2 idle");
	c_latch: cover property ($rose(o_straps_valid));
	c_pd: cover property (!i_power_down_n);
	c_run: cover property (o_outputs_enabled && i_power_down_n);
	c_ref: cover property (o_outputs_enabled && o_pin2_is_ref_out);
endmodule
bind slcf_top slcf_props u_props (.*);

// ### verif/slcf_board.sv
// Purpose: Board straps and clock loads
// Assumes: Low enable means driven
// Notes: Released pin goes to strap level
`timescale 1ns/1ps
module slcf_board (
	input wire logic [4:0] i_oe_n,
	input wire logic [4:0] i_drv,
	input wire logic [4:0] i_strap,
	output logic [4:0] o_pin
);
	assign o_pin = (i_drv & ~i_oe_n) | (i_strap & i_oe_n);
endmodule

// ### verif/slcf_top_tb.sv
// Purpose: Bench for slcf_top
// Assumes: Small sample count
// Notes: LFSR stimulus
`timescale 1ns/1ps
module slcf_top_tb;
	localparam int SC = 8;
	// Two sync edges, window entry edge, latch register
	localparam int LAT = 4;
	localparam int NT = 6;
	localparam int WD = NT * (SC + 40) * 2;
	logic clk = 0, rstn = 0, sg = 0, mi = 0, pd = 1, rs = 0;
	logic [4:0] dc = 5'h00, st = 5'h00, pin, oe_n, dp;
	logic [12:0] cp;
	logic [3:0] fs;
	logic md, p2oe, p2o, vld, stb, en;
	logic [31:0] r = 32'hD720E4AD;
	int num_errors = 0, samples_checked = 0, n;
	slcf_top #(.SAMPLE_CYCLES(SC)) dut (.i_ref_clk(clk), .i_rstn(rstn),
		.i_supply_good(sg), .i_memory_clock_in(mi), .i_power_down_n(pd),
		.i_dual_pin(pin), .i_dual_clk(dc), .i_ref_clk_src(rs),
		.o_memory_clock_copies(cp), .o_dual_pin(dp), .o_dual_pin_oe_n(oe_n),
		.o_freq_select_straps(fs), .o_pin2_is_ref_out(md),
		.o_pin2_oe_n(p2oe), .o_pin2_out(p2o), .o_straps_valid(vld),
		.o_latch_strobe(stb), .o_outputs_enabled(en));
	slcf_board brd (.i_oe_n(oe_n), .i_drv(dp), .i_strap(st), .o_pin(pin));
	initial forever #50 clk = ~clk;
	function automatic logic [31:0] nx(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [12:0] ecp(logic p, logic m);
		return p ? {13{m}} : 13'h0000;
	endfunction
	always @(posedge clk)
	begin
		r <= nx(r);
		mi <= r[0];
		pd <= r[1] | r[2];
		dc <= r[7:3];
		rs <= r[8];
	end
	task automatic chk(string nm, logic [12:0] e, logic [12:0] g);
		samples_checked++;
		if (e !== g)
		begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic run(logic [4:0] s);
		rstn <= 0;
		sg <= 0;
		st <= s;
		repeat (10) @(posedge clk);
		rstn <= 1;
		@(posedge clk);
		sg <= 1;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
			chk("hiz", 5'h1F, oe_n);
			chk("cp", ecp(pd, mi), cp);
			chk("vld", n == SC + LAT, vld);
		end while (!stb && n < SC + 9);
		chk("wait", SC + LAT, n);
		chk("en0", 1'b0, en);
		chk("fs", s[3:0], fs);
		chk("md", s[4], md);
		@(posedge clk);
		st <= ~s;
		sg <= 0;
		repeat (3) @(negedge clk);
		chk("oe", 5'h00, oe_n);
		chk("en", 1'b1, en);
		chk("stb", 1'b0, stb);
		chk("dp", dc, dp);
		chk("p2oe", !s[4], p2oe);
		chk("p2o", s[4] & rs, p2o);
		chk("hold", s, {md, fs});
		chk("cp", ecp(pd, mi), cp);
		@(posedge clk);
	endtask
	initial
	begin
		for (int k = 0; k < NT; k++)
		begin
			run(k == 0 ? 5'h00 : k == 1 ? 5'h1F : r[4:0]);
			$display("test %0d done", k);
		end
		give_verdict();
	end
	initial
	begin
		repeat (WD) @(posedge clk);
		num_errors++;
		give_verdict();
	end
endmodule
